// [ea_defines.vh]
`ifndef EA_DEFINES_VH
`define EA_DEFINES_VH

// ************************************
// addressing modes
// ************************************
`define MODE_W 3
`define MODE_REG_DIRECT 3'h0
`define MODE_REG_INDIRECT 3'h1
`define MODE_POST_INC 3'h2
`define MODE_PRE_DEC 3'h3
`define MODE_REG_DISP4 3'h4
`define MODE_REG_INDEX 3'h5
`define MODE_GBR_DISP8 3'h6
`define MODE_GBR_INDEX 3'h7

// ************************************
// operand sizes
// ************************************
`define SIZE_W 2
`define SIZE_BYTE 2'h0
`define SIZE_WORD 2'h1
`define SIZE_LONG 2'h2

// ************************************
// widths and reset values
// ************************************
`define DATA_W 32
`define DISP4_W 4
`define DISP8_W 8
`define ADDR_RST 32'h00000000

`endif

// [ea_scaler.v]
`timescale 1ns/10ps
`default_nettype none

// ************************************
// zero-extend and scale displacement
// ************************************
module ea_scaler #(
    parameter WIDTH = 32
) (
    input wire [7:0] disp,
    input wire [1:0] size,
    output reg [WIDTH-1:0] scaled
);
    always @* begin
        // zero extension, never sign extension
        case (size)
            2'h0: scaled = {{(WIDTH-8){1'b0}}, disp};
            2'h1: scaled = {{(WIDTH-9){1'b0}}, disp, 1'b0};
            2'h2: scaled = {{(WIDTH-10){1'b0}}, disp, 2'b00};
            default: scaled = {{(WIDTH-10){1'b0}}, disp, 2'b00};
        endcase
    end
endmodule

`default_nettype wire

// [effective_address_unit.v]
`timescale 1ns/10ps
`default_nettype none
`include "ea_defines.vh"

// Operation
// - register direct: register is the operand, no memory access
// - register indirect: address is register value, register unchanged
// - post-increment: address is old value, then add 1/2/4 to register
// - pre-decrement: subtract 1/2/4, write back, address is reduced value
// - register plus 4-bit zero-extended displacement scaled by size
// - scaling: byte x1, word x2, longword x4, zero extension only
// - global base plus 8-bit zero-extended displacement scaled by size
// - global base plus index register zero, unscaled
// - all additions and subtractions are full 32-bit
module effective_address_unit #(
    parameter WIDTH = 32
) (
    input wire ref_clk,
    input wire reset_n,
    input wire req_valid,
    input wire [2:0] mode,
    input wire [1:0] op_size,
    input wire [7:0] offset_field,
    input wire [WIDTH-1:0] general_register_n,
    input wire [WIDTH-1:0] index_register_zero,
    input wire [WIDTH-1:0] global_base_register,
    output reg ea_valid_q,
    output reg mem_access_q,
    output reg [WIDTH-1:0] ea_addr_q,
    output reg [WIDTH-1:0] operand_q,
    output reg reg_wb_q,
    output reg [WIDTH-1:0] reg_wb_value_q
);
    // ************************************
    // reset release
    // ************************************
    reg rst_meta_q;
    reg rst_sync_q;
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ************************************
    // step and mode decode
    // ************************************
    function [WIDTH-1:0] size_step;
        input [1:0] sz;
        begin
            case (sz)
                `SIZE_BYTE: size_step = {{(WIDTH-3){1'b0}}, 3'h1};
                `SIZE_WORD: size_step = {{(WIDTH-3){1'b0}}, 3'h2};
                default: size_step = {{(WIDTH-3){1'b0}}, 3'h4};
            endcase
        end
    endfunction

    // every mode but register direct goes to memory
    function mode_accesses;
        input [2:0] md;
        begin
            case (md)
                `MODE_REG_DIRECT: mode_accesses = 1'b0;
                default: mode_accesses = 1'b1;
            endcase
        end
    endfunction

    // only the stepping modes hand a new value back
    function mode_writes_back;
        input [2:0] md;
        begin
            case (md)
                `MODE_POST_INC: mode_writes_back = 1'b1;
                `MODE_PRE_DEC: mode_writes_back = 1'b1;
                default: mode_writes_back = 1'b0;
            endcase
        end
    endfunction

    // ************************************
    // displacement scaling
    // ************************************
    localparam SCALERS = 2;
    localparam SEL_DISP4 = 0;
    localparam SEL_DISP8 = 1;

    wire [7:0] disp_raw [0:SCALERS-1];
    wire [WIDTH-1:0] disp_scaled [0:SCALERS-1];
    wire [WIDTH-1:0] disp4_scaled;
    wire [WIDTH-1:0] disp8_scaled;

    // 4-bit field, upper nibble dropped
    assign disp_raw[SEL_DISP4] = {4'h0, offset_field[3:0]};
    assign disp_raw[SEL_DISP8] = offset_field;

    genvar gi;
    generate
        for (gi = 0; gi < SCALERS; gi = gi + 1) begin : g_scale
            ea_scaler #(.WIDTH(WIDTH)) u_ea_scaler (
                .disp(disp_raw[gi]),
                .size(op_size),
                .scaled(disp_scaled[gi])
            );
        end
    endgenerate

    assign disp4_scaled = disp_scaled[SEL_DISP4];
    assign disp8_scaled = disp_scaled[SEL_DISP8];

    // ************************************
    // candidate sums, all full width
    // ************************************
    wire [WIDTH-1:0] step;
    wire [WIDTH-1:0] rn_plus_step;
    wire [WIDTH-1:0] rn_minus_step;
    wire [WIDTH-1:0] rn_plus_disp4;
    wire [WIDTH-1:0] rn_plus_index;
    wire [WIDTH-1:0] base_plus_disp8;
    wire [WIDTH-1:0] base_plus_index;

    assign step = size_step(op_size);
    assign rn_plus_step = general_register_n + step;
    assign rn_minus_step = general_register_n - step;
    assign rn_plus_disp4 = general_register_n + disp4_scaled;
    assign rn_plus_index = general_register_n + index_register_zero;
    assign base_plus_disp8 = global_base_register + disp8_scaled;
    assign base_plus_index = global_base_register + index_register_zero;

    // ************************************
    // request decode
    // ************************************
    wire access_req;
    wire wb_req;

    assign access_req = req_valid && mode_accesses(mode);
    assign wb_req = req_valid && mode_writes_back(mode);

    // ************************************
    // address calculation
    // ************************************
    reg ea_valid_d;
    reg mem_access_d;
    reg [WIDTH-1:0] ea_addr_d;
    reg [WIDTH-1:0] operand_d;
    reg reg_wb_d;
    reg [WIDTH-1:0] reg_wb_value_d;

    always @* begin
        ea_valid_d = req_valid;
        mem_access_d = access_req;
        reg_wb_d = wb_req;
        ea_addr_d = `ADDR_RST;
        operand_d = `ADDR_RST;
        reg_wb_value_d = general_register_n;
        if (req_valid) begin
            case (mode)
                `MODE_REG_DIRECT: begin
                    operand_d = general_register_n;
                end
                `MODE_REG_INDIRECT: begin
                    ea_addr_d = general_register_n;
                end
                `MODE_POST_INC: begin
                    ea_addr_d = general_register_n;
                    reg_wb_value_d = rn_plus_step;
                end
                `MODE_PRE_DEC: begin
                    ea_addr_d = rn_minus_step;
                    reg_wb_value_d = rn_minus_step;
                end
                `MODE_REG_DISP4: begin
                    ea_addr_d = rn_plus_disp4;
                end
                `MODE_REG_INDEX: begin
                    ea_addr_d = rn_plus_index;
                end
                `MODE_GBR_DISP8: begin
                    ea_addr_d = base_plus_disp8;
                end
                `MODE_GBR_INDEX: begin
                    ea_addr_d = base_plus_index;
                end
                default: begin
                    ea_addr_d = `ADDR_RST;
                end
            endcase
        end
    end

    // ************************************
    // output registers
    // ************************************
    // control flags
    always @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            ea_valid_q <= 1'b0;
            mem_access_q <= 1'b0;
            reg_wb_q <= 1'b0;
        end else begin
            ea_valid_q <= ea_valid_d;
            mem_access_q <= mem_access_d;
            reg_wb_q <= reg_wb_d;
        end
    end

    // address and data words
    always @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            ea_addr_q <= `ADDR_RST;
            operand_q <= `ADDR_RST;
            reg_wb_value_q <= `ADDR_RST;
        end else begin
            ea_addr_q <= ea_addr_d;
            operand_q <= operand_d;
            reg_wb_value_q <= reg_wb_value_d;
        end
    end
endmodule

`default_nettype wire

// [effective_address_unit_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module ea_checker (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic req_valid,
    input wire logic [2:0] mode,
    input wire logic [1:0] op_size,
    input wire logic [7:0] offset_field,
    input wire logic [31:0] general_register_n,
    input wire logic [31:0] index_register_zero,
    input wire logic [31:0] global_base_register,
    input wire logic ea_valid_q,
    input wire logic mem_access_q,
    input wire logic [31:0] ea_addr_q,
    input wire logic [31:0] operand_q,
    input wire logic reg_wb_q,
    input wire logic [31:0] reg_wb_value_q
);
    logic [31:0] k, e, e_q;
    logic [31:0] w_q, rn_q;
    assign k = op_size == 2'h0 ? 32'h1 : op_size == 2'h1 ? 32'h2 : 32'h4;
    assign e = mode == 3'h3 ? general_register_n - k
        : mode == 3'h4 ? general_register_n + {28'h0, offset_field[3:0]} * k
        : mode == 3'h5 ? general_register_n + index_register_zero
        : mode == 3'h6 ? global_base_register + {24'h0, offset_field} * k
        : mode == 3'h7 ? global_base_register + index_register_zero : general_register_n;
    always @(posedge ref_clk) begin
        e_q <= e;
        w_q <= general_register_n + k;
        rn_q <= general_register_n;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_direct_no_access: assert property (req_valid && mode == 3'h0
        |=> !mem_access_q && !reg_wb_q && operand_q == rn_q)
        else $error("bad");
    a_indirect_addr: assert property (req_valid && mode == 3'h1
        |=> ea_addr_q == e_q && !reg_wb_q)
        else $error("bad");
    a_post_inc: assert property (req_valid && mode == 3'h2
        |=> ea_addr_q == e_q && reg_wb_q && reg_wb_value_q == w_q)
        else $error("bad");
    a_pre_dec: assert property (req_valid && mode == 3'h3
        |=> reg_wb_value_q == e_q && ea_addr_q == e_q && reg_wb_q)
        else $error("bad");
    a_reg_disp: assert property (req_valid && mode == 3'h4 |=> ea_addr_q == e_q)
        else $error("bad");
    a_reg_index: assert property (req_valid && mode == 3'h5
        |=> ea_addr_q == e_q && !reg_wb_q)
        else $error("bad");
    a_base_disp: assert property (req_valid && mode == 3'h6 |=> ea_addr_q == e_q)
        else $error("bad");
    a_base_index: assert property (req_valid && mode == 3'h7 |=> ea_addr_q == e_q)
        else $error("bad");
    a_valid_pulse: assert property (req_valid |=> ea_valid_q)
        else $error("request gave no valid pulse");
    a_idle_quiet: assert property (!req_valid |=> !mem_access_q && !reg_wb_q && !ea_valid_q)
        else $error("bad");
endmodule
bind effective_address_unit ea_checker u_ea_checker (.*);
`default_nettype wire

// [core_side.sv]
`timescale 1ns/10ps
`default_nettype none
module core_side (
    input wire logic ref_clk,
    input wire logic load,
    input wire logic [31:0] rn_load,
    input wire logic reg_wb_q,
    input wire logic [31:0] reg_wb_value_q,
    output logic [31:0] rn
);
    // register file entry, takes write-back a cycle after the answer
    always @(posedge ref_clk)
        if (load) rn <= rn_load;
        else if (reg_wb_q) rn <= reg_wb_value_q;
endmodule
`default_nettype wire

// [test_effective_address_unit.sv]
`timescale 1ns/10ps
`default_nettype none
module test_effective_address_unit;
    logic ref_clk, reset_n, req_valid, load, ea_valid_q, mem_access_q, reg_wb_q;
    logic [2:0] mode;
    logic [1:0] op_size;
    logic [7:0] offset_field;
    logic [31:0] r0, gb, rn, rn_load, ea_addr_q, operand_q, reg_wb_value_q;
    int errors, total_checks;
    effective_address_unit u_effective_address_unit (.ref_clk, .reset_n, .req_valid, .mode,
        .op_size, .offset_field, .general_register_n(rn), .index_register_zero(r0),
        .global_base_register(gb), .ea_valid_q, .mem_access_q, .ea_addr_q, .operand_q,
        .reg_wb_q, .reg_wb_value_q);
    core_side u_core_side (.ref_clk, .load, .rn_load, .reg_wb_q, .reg_wb_value_q, .rn);
    task chk(input logic [130:0] seen, input logic [130:0] want);
        total_checks++;
        if (seen !== want) begin
            errors++;
            $display("mismatch %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task stop_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task ld(input logic [31:0] v);
        @(posedge ref_clk);
        load <= 1'b1;
        rn_load <= v;
        @(posedge ref_clk);
        load <= 1'b0;
    endtask
    task go(input logic [2:0] m, input logic [1:0] s, input logic [31:0] v);
        logic [31:0] k, e, w;
        logic [130:0] x;
        k = s == 2'h3 ? 32'h4 : 32'h1 << s;
        w = m == 3'h2 ? v + k : m == 3'h3 ? v - k : v;
        e = m == 3'h0 ? 32'h0 : m < 3'h3 ? v : m == 3'h3 ? w : m == 3'h4 ? v + offset_field[3:0] * k
            : m == 3'h5 ? v + r0 : m == 3'h6 ? gb + offset_field * k : gb + r0;
        x = {1'b1, m != 3'h0, m == 3'h2 || m == 3'h3, e, w, m == 3'h0 ? v : 32'h0};
        @(posedge ref_clk);
        req_valid <= 1'b1;
        mode <= m;
        op_size <= s;
        @(posedge ref_clk);
        req_valid <= 1'b0;
        #1;
        chk({ea_valid_q, mem_access_q, reg_wb_q, ea_addr_q, reg_wb_value_q, operand_q}, x);
    endtask
    task t_modes;
        for (int m = 0; m < 8; m++)
            for (int s = 0; s < 4; s++) begin
                ld(32'hFFFFFFFE);
                go(m[2:0], s[1:0], 32'hFFFFFFFE);
            end
    endtask
    task t_chain;
        ld(32'h100);
        go(3'h2, 2'h2, 32'h100);
        go(3'h2, 2'h0, 32'h104);
        go(3'h3, 2'h1, 32'h105);
        go(3'h1, 2'h0, 32'h103);
    endtask
    task t_burst;
        // back-to-back requests, then the pulse must fall
        ld(32'h200);
        @(posedge ref_clk);
        req_valid <= 1'b1;
        mode <= 3'h5;
        op_size <= 2'h1;
        @(posedge ref_clk);
        mode <= 3'h7;
        #1;
        chk({ea_valid_q, ea_addr_q}, {1'b1, 32'h210});
        @(posedge ref_clk);
        req_valid <= 1'b0;
        #1;
        chk({ea_valid_q, ea_addr_q}, {1'b1, 32'hFFFFFF10});
        @(posedge ref_clk);
        #1;
        chk({ea_valid_q, mem_access_q, reg_wb_q, ea_addr_q, reg_wb_value_q}, {3'h0, 32'h0, 32'h200});
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        {reset_n, req_valid, load, mode, op_size} = 8'h0;
        offset_field = 8'hFB;
        rn_load = 32'h0;
        r0 = 32'h10;
        gb = 32'hFFFFFF00;
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_modes;
        t_chain;
        t_burst;
        stop_test;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        stop_test;
    end
endmodule
`default_nettype wire
